// ===== hdl/gas_cmd_mode_ctrl.sv
// ascii command interpreter with mode, filter, analogue scale and report stream
`timescale 1ns/10ps
`default_nettype none
module gas_cmd_mode_ctrl
  import gas_cmd_pkg::*;
#(
  parameter int REPORT_PERIOD = REPORT_CYCLES,
  parameter int DEFER_LIMIT   = DEFER_CYCLES,
  parameter int FIFO_DEPTH    = 16
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // received characters from the uart
  input wire logic [7:0]  rxData,
  input wire logic        rxValid,
  // characters to the uart
  output logic [7:0]      txData,
  output logic            txValid,
  input wire logic        txReady,
  // measurement engine
  input wire logic [15:0] gasFiltered,
  input wire logic [15:0] humTenths,
  input wire logic [15:0] tempTenths,
  input wire logic        measBusy,
  output logic            measEnable,
  // option strap and mode retention store
  input wire logic        thFitted,
  input wire logic [1:0]  bootMode,
  output logic [1:0]      modeStore,
  // settings
  output logic [1:0]      currentMode,
  output logic            fieldsAll,
  output logic [15:0]     filterDepth,
  output logic [15:0]     analogScale,
  output logic            analogEn,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  output logic [31:0]     regRdData
);
  generate
    if (REPORT_PERIOD < 2 || DEFER_LIMIT < 1) begin : g_bad
      $error("gas_cmd_mode_ctrl: period and defer limit too small");
    end
  endgenerate

  // -------------------------------------------------------------
  // option strap synchroniser
  // -------------------------------------------------------------
  logic [2:0] fitSync;
  logic       fitted;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fitSync <= '0;
      fitted  <= 1'b0;
    end else begin
      fitSync <= {fitSync[1:0], thFitted};
      if (fitSync[1] == fitSync[2]) fitted <= fitSync[2];
    end
  end

  // -------------------------------------------------------------
  // line parser
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    P_LETTER = 3'b001,
    P_BODY   = 3'b010,
    P_LF     = 3'b100
  } parse_e;

  parse_e      pState;
  logic [7:0]  cmdLetter;
  logic [15:0] acc;
  logic        inNum;
  logic        bad;
  logic [1:0]  argCnt;
  logic [15:0] arg0;
  logic [15:0] arg1;
  logic        cmdHeld;

  wire         isDigit   = (rxData >= CH_ZERO) && (rxData <= CH_NINE);
  wire  [19:0] accNext   = {4'h0, acc} * 20'd10 + {16'h0, rxData[3:0] - CH_ZERO[3:0]};
  wire         rxTake    = rxValid && !cmdHeld;
  wire         closeNum  = rxTake && (pState == P_BODY) && inNum &&
                           (rxData == CH_SPACE || rxData == CH_CR);
  wire         lineEnd   = rxTake && (pState == P_LF) && (rxData == CH_LF);

  // syntax of each known command
  wire okNoArg = (argCnt == 2'd0);
  wire okMode  = (argCnt == 2'd1) && (arg0 <= 16'(MODE_POLL));
  wire okFset  = (argCnt == 2'd1) && (arg0 != 16'h0000);
  wire okField = (argCnt == 2'd1);
  wire okParam = (argCnt == 2'd2) && (arg0 <= 16'h0001) && (arg1 <= MAX_SCALE_BYTE);
  wire lineOk  = !bad && (
                 ((cmdLetter == CH_TEMP || cmdLetter == CH_HUM || cmdLetter == CH_GAS ||
                   cmdLetter == CH_FGET) && okNoArg) ||
                 (cmdLetter == CH_MODE && okMode) ||
                 (cmdLetter == CH_FSET && okFset) ||
                 (cmdLetter == CH_FIELD && okField) ||
                 (cmdLetter == CH_PARAM && okParam));

  // the uart has no flow control: bytes during a pending command are lost
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pState    <= P_LETTER;
      cmdLetter <= '0;
      acc       <= '0;
      inNum     <= 1'b0;
      bad       <= 1'b0;
      argCnt    <= '0;
      arg0      <= '0;
      arg1      <= '0;
    end else if (rxTake) begin
      unique case (pState)
        P_LETTER: begin
          cmdLetter <= rxData;
          acc       <= '0;
          inNum     <= 1'b0;
          argCnt    <= '0;
          bad       <= (rxData == CH_CR) || (rxData == CH_SPACE);
          pState    <= (rxData == CH_CR) ? P_LF : P_BODY;
        end
        P_BODY: begin
          if (closeNum) begin
            if (argCnt == 2'd0) arg0 <= acc;
            else if (argCnt == 2'd1) arg1 <= acc;
            else bad <= 1'b1;
            argCnt <= argCnt + 2'd1;
            acc    <= '0;
            inNum  <= 1'b0;
          end
          if (isDigit) begin
            acc   <= accNext[15:0];
            inNum <= 1'b1;
            if (accNext[19:16] != 4'h0) bad <= 1'b1;
          end else if (rxData != CH_SPACE && rxData != CH_CR) begin
            bad <= 1'b1;
          end
          if (rxData == CH_CR) pState <= P_LF;
        end
        P_LF: begin
          if (rxData == CH_LF) pState <= P_LETTER;
          else bad <= 1'b1;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // command hold, deferral and execution
  // -------------------------------------------------------------
  localparam int DW = $clog2(DEFER_LIMIT + 1);
  logic [DW-1:0] deferCnt;
  logic          bootDone;
  logic [1:0]    mode;
  logic [7:0]    scaleHi;
  logic [7:0]    scaleLo;

  typedef enum logic [6:0] {
    E_IDLE   = 7'b0000001,
    E_LETTER = 7'b0000010,
    E_SPACE  = 7'b0000100,
    E_CONV   = 7'b0001000,
    E_DIGIT  = 7'b0010000,
    E_CR     = 7'b0100000,
    E_LF     = 7'b1000000
  } emit_e;
  emit_e eState;

  wire streaming = (mode == MODE_STREAM);
  wire eIdle     = (eState == E_IDLE);
  wire measCmd   = (cmdLetter == CH_TEMP) || (cmdLetter == CH_HUM) || (cmdLetter == CH_GAS);
  wire refused   = (mode == MODE_SLEEP) && measCmd;
  wire waitMeas  = streaming && measBusy && (deferCnt != DW'(DEFER_LIMIT));
  wire execCmd   = cmdHeld && eIdle && !waitMeas;
  wire loadCmd   = execCmd && !refused;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmdHeld  <= 1'b0;
      deferCnt <= '0;
    end else begin
      if (lineEnd && lineOk) cmdHeld <= 1'b1;
      else if (execCmd) cmdHeld <= 1'b0;
      if (!cmdHeld || execCmd) deferCnt <= '0;
      else if (streaming && measBusy) deferCnt <= deferCnt + 1'b1;
    end
  end

  // register file write of the filter; a command in the same cycle wins
  wire regFilterWr = regWr && (regAddr == REG_FILTER) && (regWrData[15:0] != 16'h0000);
  wire [15:0] nextScale = (arg0[0] == 1'b0) ? {arg1[7:0], scaleLo} : {scaleHi, arg1[7:0]};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bootDone    <= 1'b0;
      mode        <= MODE_STREAM;
      modeStore   <= MODE_STREAM;
      fieldsAll   <= 1'b0;
      filterDepth <= FILTER_DEFAULT;
      scaleHi     <= '0;
      scaleLo     <= '0;
      analogEn    <= 1'b0;
    end else if (!bootDone) begin
      bootDone  <= 1'b1;
      mode      <= (bootMode == MODE_POLL) ? MODE_POLL : MODE_STREAM;
      modeStore <= (bootMode == MODE_POLL) ? MODE_POLL : MODE_STREAM;
    end else begin
      if (regFilterWr) filterDepth <= regWrData[15:0];
      if (loadCmd) begin
        unique case (cmdLetter)
          CH_MODE: begin
            mode <= arg0[1:0];
            if (arg0[1:0] != MODE_SLEEP) modeStore <= arg0[1:0];
          end
          CH_FSET:  filterDepth <= arg0;
          CH_FIELD: fieldsAll <= (arg0 == FIELD_ALL);
          CH_PARAM: begin
            if (arg0[0] == 1'b0) scaleHi <= arg1[7:0];
            else scaleLo <= arg1[7:0];
            analogEn <= (nextScale != 16'h0000);
          end
          default: ;
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // periodic report timer
  // -------------------------------------------------------------
  localparam int RW = $clog2(REPORT_PERIOD);
  logic [RW-1:0] repCnt;
  logic          repPend;
  wire           loadRep = eIdle && !loadCmd && repPend && streaming;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      repCnt  <= '0;
      repPend <= 1'b0;
    end else begin
      if (!streaming) begin
        repCnt  <= '0;
        repPend <= 1'b0;
      end else if (repCnt == RW'(REPORT_PERIOD - 1)) begin
        repCnt  <= '0;
        repPend <= 1'b1;
      end else begin
        repCnt <= repCnt + 1'b1;
        if (loadRep) repPend <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // response tokens: letters and five digit numbers
  // -------------------------------------------------------------
  logic [15:0] tokVal [TOKENS];
  logic [TOKENS-1:0] tokNum;
  logic [2:0]  tokLast;
  logic [2:0]  tokIdx;
  logic [2:0]  digIdx;

  wire [15:0] tempField = fitted ? (tempTenths + TEMP_OFFSET) : 16'h0000;
  wire [15:0] humField  = fitted ? humTenths : 16'h0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < TOKENS; i++) tokVal[i] <= '0;
      tokNum  <= '0;
      tokLast <= '0;
    end else if (loadRep && fieldsAll) begin
      tokVal[0] <= {8'h00, CH_HUM};
      tokVal[1] <= humField;
      tokVal[2] <= {8'h00, CH_TEMP};
      tokVal[3] <= tempField;
      tokVal[4] <= {8'h00, CH_GAS};
      tokVal[5] <= gasFiltered;
      tokNum    <= 6'b101010;
      tokLast   <= 3'd5;
    end else if (loadRep || loadCmd) begin
      tokVal[0] <= {8'h00, loadRep ? CH_GAS : cmdLetter};
      tokNum    <= 6'b000010;
      tokLast   <= 3'd1;
      if (loadRep) begin
        tokVal[1] <= gasFiltered;
      end else begin
        unique case (cmdLetter)
          CH_TEMP:  tokVal[1] <= tempField;
          CH_HUM:   tokVal[1] <= humField;
          CH_GAS:   tokVal[1] <= gasFiltered;
          CH_FGET:  tokVal[1] <= filterDepth;
          CH_PARAM: begin
            tokVal[1] <= arg0;
            tokVal[2] <= arg1;
            tokNum    <= 6'b000110;
            tokLast   <= 3'd2;
          end
          default:  tokVal[1] <= arg0;
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // character emitter into the fifo
  // -------------------------------------------------------------
  byte_stream_if #(.WIDTH(8)) fillBus ();
  byte_stream_if #(.WIDTH(8)) drainBus ();

  logic    convDone;
  digits_t convDigits;

  wire pushing = (eState == E_LETTER) || (eState == E_SPACE) || (eState == E_DIGIT) ||
                 (eState == E_CR) || (eState == E_LF);
  wire fire    = fillBus.valid && fillBus.ready;
  wire lastTok = (tokIdx == tokLast);
  wire convGo  = (eState == E_SPACE) && fire && tokNum[tokIdx];
  wire [7:0] digitChar = {4'h3, convDigits[3'd4 - digIdx]};

  assign fillBus.valid = pushing;
  assign fillBus.data  = (eState == E_LETTER) ? tokVal[tokIdx][7:0] :
                         (eState == E_SPACE)  ? CH_SPACE :
                         (eState == E_DIGIT)  ? digitChar :
                         (eState == E_CR)     ? CH_CR : CH_LF;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eState <= E_IDLE;
      tokIdx <= '0;
      digIdx <= '0;
    end else begin
      unique case (eState)
        E_IDLE: begin
          tokIdx <= '0;
          if (loadCmd || loadRep) eState <= E_LETTER;
        end
        E_LETTER: if (fire) begin
          eState <= lastTok ? E_CR : E_SPACE;
          if (!lastTok) tokIdx <= tokIdx + 3'd1;
        end
        E_SPACE: if (fire) eState <= tokNum[tokIdx] ? E_CONV : E_LETTER;
        E_CONV: begin
          digIdx <= '0;
          if (convDone) eState <= E_DIGIT;
        end
        E_DIGIT: if (fire) begin
          digIdx <= digIdx + 3'd1;
          if (digIdx == 3'd4) begin
            eState <= lastTok ? E_CR : E_SPACE;
            if (!lastTok) tokIdx <= tokIdx + 3'd1;
          end
        end
        E_CR: if (fire) eState <= E_LF;
        E_LF: if (fire) eState <= E_IDLE;
      endcase
    end
  end

  dec5_convert u_conv (
    .clk    (clk),
    .sys_rst(sys_rst),
    .start  (convGo),
    .value  (tokVal[tokIdx]),
    .done   (convDone),
    .digits (convDigits)
  );

  stream_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk    (clk),
    .sys_rst(sys_rst),
    .fill   (fillBus),
    .drain  (drainBus)
  );

  // -------------------------------------------------------------
  // transmit register and status outputs
  // -------------------------------------------------------------
  assign drainBus.ready = !txValid || txReady;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txValid     <= 1'b0;
      txData      <= '0;
      measEnable  <= 1'b0;
      currentMode <= MODE_STREAM;
      analogScale <= '0;
    end else begin
      if (drainBus.ready) begin
        txValid <= drainBus.valid;
        if (drainBus.valid) txData <= drainBus.data;
      end
      measEnable  <= bootDone && (mode != MODE_SLEEP);
      currentMode <= mode;
      analogScale <= {scaleHi, scaleLo};
    end
  end

  // -------------------------------------------------------------
  // register port
  // -------------------------------------------------------------
  wire [31:0] statusWord = {26'h0, cmdHeld, fitted, analogEn, fieldsAll, mode};
  wire [31:0] readMux    = (regAddr == REG_STATUS) ? statusWord :
                           (regAddr == REG_FILTER) ? {16'h0, filterDepth} :
                           (regAddr == REG_SCALE)  ? {16'h0, scaleHi, scaleLo} : 32'h0;

  always_ff @(posedge clk) begin
    if (sys_rst) regRdData <= '0;
    else if (regRd) regRdData <= readMux;
    else regRdData <= '0;
  end
endmodule
`default_nettype wire

// ===== hdl/gas_cmd_pkg.sv
// shared constants and types of the ascii command interpreter
package gas_cmd_pkg;
  // -------------------------------------------------------------
  // characters
  // -------------------------------------------------------------
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_NINE  = 8'h39;
  localparam logic [7:0] CH_TEMP  = 8'h54;  // T
  localparam logic [7:0] CH_HUM   = 8'h48;  // H
  localparam logic [7:0] CH_GAS   = 8'h5A;  // Z
  localparam logic [7:0] CH_FSET  = 8'h41;  // A
  localparam logic [7:0] CH_FGET  = 8'h61;  // a
  localparam logic [7:0] CH_MODE  = 8'h4B;  // K
  localparam logic [7:0] CH_FIELD = 8'h4D;  // M
  localparam logic [7:0] CH_PARAM = 8'h50;  // P
  // -------------------------------------------------------------
  // values
  // -------------------------------------------------------------
  localparam logic [15:0] TEMP_OFFSET    = 16'h03E8;  // 1000
  localparam logic [15:0] FIELD_ALL      = 16'h1044;  // 4164
  localparam logic [15:0] FILTER_DEFAULT = 16'h0010;  // 16
  localparam logic [15:0] MAX_SCALE_BYTE = 16'h00FF;
  localparam logic [1:0]  MODE_SLEEP     = 2'h0;
  localparam logic [1:0]  MODE_STREAM    = 2'h1;
  localparam logic [1:0]  MODE_POLL      = 2'h2;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int CLK_HZ         = 40_000_000;
  localparam int REPORT_MS      = 500;
  localparam int DEFER_MS       = 100;
  localparam int REPORT_CYCLES  = CLK_HZ / 1000 * REPORT_MS;
  localparam int DEFER_CYCLES   = CLK_HZ / 1000 * DEFER_MS;
  localparam int TOKENS         = 6;
  // -------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_FILTER = 8'h04;
  localparam logic [7:0] REG_SCALE  = 8'h08;
  typedef logic [4:0][3:0] digits_t;
endpackage

// ===== hdl/byte_stream_if.sv
// valid/ready stream carrier between internal modules
`timescale 1ns/10ps
`default_nettype none
interface byte_stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface
`default_nettype wire

// ===== hdl/stream_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // streams
  byte_stream_if.sink     fill,
  byte_stream_if.source   drain
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || $bits(fill.data) != WIDTH) begin : g_bad
      $error("stream_fifo: DEPTH must be a power of two and WIDTH match the stream");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  wire              push = fill.valid && fill.ready;
  wire              pop  = drain.valid && drain.ready;

  assign fill.ready  = (count != (AW+1)'(DEPTH));
  assign drain.valid = (count != '0);
  assign drain.data  = mem[rdPtr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= fill.data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop) rdPtr <= rdPtr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ===== hdl/dec5_convert.sv
// serial binary to five decimal digits by repeated subtraction
`timescale 1ns/10ps
`default_nettype none
module dec5_convert
  import gas_cmd_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // request
  input wire logic        start,
  input wire logic [15:0] value,
  // result
  output logic            done,
  output digits_t         digits
);
  logic [15:0] rem;
  logic [2:0]  pos;
  logic        busy;
  logic [15:0] weight;

  always_comb begin
    unique case (pos)
      3'd0:    weight = 16'h2710;
      3'd1:    weight = 16'h03E8;
      3'd2:    weight = 16'h0064;
      3'd3:    weight = 16'h000A;
      default: weight = 16'h0001;
    endcase
  end

  wire take = busy && (rem >= weight);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rem    <= '0;
      pos    <= '0;
      busy   <= 1'b0;
      done   <= 1'b0;
      digits <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem    <= value;
        pos    <= '0;
        busy   <= 1'b1;
        digits <= '0;
      end else if (take) begin
        rem <= rem - weight;
        digits[3'd4 - pos] <= digits[3'd4 - pos] + 4'h1;
      end else if (busy) begin
        pos <= pos + 3'd1;
        if (pos == 3'd4) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/gas_cmd_mode_ctrl_chk.sv
// concurrent checks on the interpreter ports
`timescale 1ns/10ps
`default_nettype none
module gas_cmd_mode_ctrl_chk
  import gas_cmd_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // watched ports
  input wire logic [7:0]  txData,
  input wire logic        txValid,
  input wire logic        txReady,
  input wire logic        measEnable,
  input wire logic [1:0]  modeStore,
  input wire logic [1:0]  currentMode,
  input wire logic [15:0] filterDepth,
  input wire logic [15:0] analogScale,
  input wire logic        analogEn,
  input wire logic [7:0]  regAddr,
  input wire logic        regRd,
  input wire logic [31:0] regRdData
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_txHold; txValid && !txReady |=> txValid && $stable(txData); endproperty
  a_txHold: assert property (p_txHold) else $error("tx char lost");
  property p_crLf; txValid && txReady && txData == CH_CR |=> !txValid || txData == CH_LF; endproperty
  a_crLf: assert property (p_crLf) else $error("cr not followed by lf");
  property p_sleepIdle; currentMode == MODE_SLEEP |-> !measEnable; endproperty
  a_sleepIdle: assert property (p_sleepIdle) else $error("measuring in sleep");
  property p_storeAwake; modeStore != MODE_SLEEP; endproperty
  a_storeAwake: assert property (p_storeAwake) else $error("sleep kept in store");
  // store updates with the internal mode except on a change to sleep, one cycle ahead of currentMode
  property p_storeFollow; $stable(currentMode) [*3] ##0 currentMode != MODE_SLEEP
    |-> $past(modeStore) == currentMode; endproperty
  a_storeFollow: assert property (p_storeFollow) else $error("store stale");
  property p_filterNz; filterDepth != 16'h0000; endproperty
  a_filterNz: assert property (p_filterNz) else $error("filter depth zero");
  property p_filterRd; regRd && regAddr == REG_FILTER |=> regRdData[15:0] == $past(filterDepth);
  endproperty
  a_filterRd: assert property (p_filterRd) else $error("filter read wrong");
  property p_analogOn; $rose(analogEn) |-> ##[0:2] analogScale != 16'h0000; endproperty
  a_analogOn: assert property (p_analogOn) else $error("analog on at zero");
  c_sleep: cover property (currentMode == MODE_SLEEP);
  c_analog: cover property ($rose(analogEn));
  c_stall: cover property (txValid && !txReady);
endmodule
bind gas_cmd_mode_ctrl gas_cmd_mode_ctrl_chk u_chk (.*);
`default_nettype wire

// ===== verification/host_model.sv
// host controller model: sends command lines and collects replies
`timescale 1ns/10ps
`default_nettype none
module host_model
  import gas_cmd_pkg::*;
(
  // clock
  input wire logic       clk,
  // command characters
  output logic [7:0]     rxData = 8'h00,
  output logic           rxValid = 1'b0,
  // reply characters
  input wire logic [7:0] txData,
  input wire logic       txValid,
  output logic           txReady = 1'b0
);
  logic [7:0] line[$];
  logic       slow = 1'b0;
  int         seed = 88008;
  // slow mode stalls so the reply fifo backs up
  always @(posedge clk) begin
    if (txValid && txReady) line.push_back(txData);
    txReady <= !slow || (($random(seed) & 3) == 0);
  end
  // idle line shows the inverse of the last char, not a stale copy
  task automatic send(input string s);
    logic [7:0] ch;
    for (int i = 0; i < s.len() + 2; i++) begin
      ch = (i < s.len()) ? s[i] : (i == s.len()) ? CH_CR : CH_LF;
      rxData <= ch;
      rxValid <= 1'b1;
      @(posedge clk);
      rxData <= ~ch;
      rxValid <= 1'b0;
      @(posedge clk);
    end
  endtask
  function automatic string scale_cmd(input int ppm, input int mult, input bit low);
    int v;
    v = ppm / mult;
    return $sformatf("P %0d %0d", low, low ? v - 256 * (v / 256) : v / 256);
  endfunction
endmodule
`default_nettype wire

// ===== verification/gas_cmd_mode_ctrl_tb.sv
// self-checking bench for the ascii command interpreter
`timescale 1ns/10ps
`default_nettype none
module gas_cmd_mode_ctrl_tb import gas_cmd_pkg::*;;
  logic        clk = 1'b0, sys_rst = 1'b1, measBusy = 1'b0, thFitted = 1'b1;
  logic        regWr = 1'b0, regRd = 1'b0, rxValid, txValid, txReady;
  logic        measEnable, fieldsAll, analogEn;
  logic [1:0]  bootMode = MODE_POLL, modeStore, currentMode;
  logic [7:0]  regAddr = 8'h00, rxData, txData;
  logic [15:0] gasFiltered, humTenths, tempTenths, filterDepth, analogScale;
  logic [31:0] regWrData = 32'h0000_0000, regRdData;
  int          seed = 88008, mismatches = 0, tests_run = 0, t, h, g, s;
  int          fv[3] = '{1, 65535, 0};
  always #12.5 clk = ~clk;
  always @(posedge clk) measBusy <= measEnable && (($random(seed) & 3) == 0);
  gas_cmd_mode_ctrl #(.REPORT_PERIOD(400), .DEFER_LIMIT(50)) u_gas_cmd_mode_ctrl (.*);
  host_model u_host_model (.*);
  function automatic string d5(input int v);
    return $sformatf("%05d", v);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // empty reply means the line must be dropped without an answer
  task automatic cmd(input string c, input string r);
    int n;
    n = 0;
    if (c.len() > 0) u_host_model.send(c);
    while (u_host_model.line.size() < r.len() + 2 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (r.len() == 0) check("silence", u_host_model.line.size(), 0);
    else if (n == 2000) begin
      mismatches++;
      summarize();
    end
    foreach (r[i]) check("reply", u_host_model.line.pop_front(), r[i]);
    if (r.len() > 0) begin
      check("cr", u_host_model.line.pop_front(), CH_CR);
      check("lf", u_host_model.line.pop_front(), CH_LF);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 check("regRdData", regRdData, e);
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic do_reset(input logic [1:0] b);
    bootMode <= b;
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    t = ($random(seed) & 511) - 200;
    h = $random(seed) & 1023;
    g = $random(seed) & 32'h0000_FFFF;
    tempTenths = t[15:0];
    humTenths = h[15:0];
    gasFiltered = g[15:0];
    do_reset(MODE_POLL);
    check("currentMode", currentMode, MODE_POLL);
    check("filterDepth", filterDepth, FILTER_DEFAULT);
    check("fieldsAll", fieldsAll, 1'b0);
    rd(REG_FILTER, FILTER_DEFAULT);
    rd(8'h0C, 32'h0000_0000);
    cmd("a", "a 00016");
    cmd("Z", {"Z ", d5(g)});
    cmd("", "");
    fv[2] = ($random(seed) & 32'h0000_FFFE) + 1;
    foreach (fv[i]) begin
      cmd($sformatf("A %0d", fv[i]), {"A ", d5(fv[i])});
      check("filterDepth", filterDepth, fv[i]);
    end
    cmd("A 0", "");
    cmd("Q 5", "");
    cmd("K 3", "");
    wr(REG_FILTER, 32'h0000_0123);
    wr(REG_FILTER, 32'h0000_0000);
    cmd("a", "a 00291");
    cmd("T", {"T ", d5(t + 1000)});
    cmd("H", {"H ", d5(h)});
    thFitted <= 1'b0;
    cmd("T", "T 00000");
    cmd("H", "H 00000");
    thFitted <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      s = (k == 0) ? 5000 : (k == 1) ? (($random(seed) & 32'h0000_FFFF) | 1) : 0;
      cmd(u_host_model.scale_cmd(s * 10, 10, 1'b0), {"P 00000 ", d5(s / 256)});
      cmd(u_host_model.scale_cmd(s * 10, 10, 1'b1), {"P 00001 ", d5(s % 256)});
      check("analogScale", analogScale, s);
      check("analogEn", analogEn, s != 0);
    end
    cmd("M 4164", "M 04164");
    check("fieldsAll", fieldsAll, 1'b1);
    cmd("K 0", "K 00000");
    check("measEnable", measEnable, 1'b0);
    cmd("Z", "");
    cmd("a", "a 00291");
    check("modeStore", modeStore, MODE_POLL);
    u_host_model.slow = 1'b1;
    cmd("K 1", "K 00001");
    repeat (2) cmd("", {"H ", d5(h), " T ", d5(t + 1000), " Z ", d5(g)});
    do_reset(MODE_SLEEP);
    u_host_model.line.delete();
    check("currentMode", currentMode, MODE_STREAM);
    cmd("", {"Z ", d5(g)});
    // fast host so both answers land well before the next report
    u_host_model.slow = 1'b0;
    cmd("a", "a 00016");
    cmd("K 2", "K 00002");
    check("modeStore", modeStore, MODE_POLL);
    cmd("M 1", "M 00001");
    check("fieldsAll", fieldsAll, 1'b0);
    cmd("", "");
    summarize();
  end
endmodule
`default_nettype wire
